// ---- rtl/gx_pkg.sv ----
package gx_pkg;
	localparam int IO_W = 8;
	localparam int PTR_W = 2;
	localparam logic [PTR_W-1:0] PTR_IN = 2'h0;
	localparam logic [PTR_W-1:0] PTR_OUT = 2'h1;
	localparam logic [PTR_W-1:0] PTR_INV = 2'h2;
	localparam logic [PTR_W-1:0] PTR_DIR = 2'h3;
	localparam logic [IO_W-1:0] DIR_RST = 8'hff;
	localparam logic [IO_W-1:0] OUT_RST = 8'hff;
	localparam logic [IO_W-1:0] INV_RST = 8'h00;
	localparam logic [IO_W-1:0] IN_RST = 8'h00;
	localparam logic [4:0] ADDR_BASE = 5'h1c;
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam int SY_SCL = 0;
	localparam int SY_SDA = 1;
	localparam int SY_A0 = 2;
	localparam int SY_A1 = 3;
	localparam int SY_RST = 4;
	localparam int SY_IO = 5;
	localparam int SYNC_W = SY_IO + IO_W;
	localparam logic [SYNC_W-1:0] SYNC_RST = 13'h1fff;
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
	} gx_state_t;
endpackage

// ---- rtl/gx_regs_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface gx_regs_if;
	import gx_pkg::*;
	logic wr_en;
	logic capture;
	logic soft_rst;
	logic [PTR_W-1:0] ptr;
	logic [IO_W-1:0] wr_data;
	logic [IO_W-1:0] pins;
	logic [IO_W-1:0] rd_data;
	logic [IO_W-1:0] out_lvl;
	logic [IO_W-1:0] dir;
	logic mismatch;
	modport ctrl (
		output wr_en, capture, soft_rst, ptr, wr_data, pins,
		input rd_data, out_lvl, dir, mismatch
	);
	modport bank (
		input wr_en, capture, soft_rst, ptr, wr_data, pins,
		output rd_data, out_lvl, dir, mismatch
	);
endinterface
`default_nettype wire

// ---- rtl/gx_regbank.sv ----
`timescale 1ns/10ps
`default_nettype none
module gx_regbank (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	gx_regs_if.bank bus
);
	import gx_pkg::*;

	function automatic logic wr_hit(input logic [PTR_W-1:0] sel, input logic en,
		input logic [PTR_W-1:0] ptr);
		wr_hit = en && (ptr == sel);
	endfunction

	logic [IO_W-1:0] dir_q, out_q, inv_q, in_q, rd_data_q;
	wire [IO_W-1:0] live_in;
	wire [IO_W-1:0] rd_mux;
	wire wr_ok;

	// Invert view
	assign live_in = bus.pins ^ inv_q;
	// Readback mux
	assign rd_mux = (bus.ptr == PTR_IN) ? live_in :
		(bus.ptr == PTR_OUT) ? out_q :
		(bus.ptr == PTR_INV) ? inv_q : dir_q;
	assign wr_ok = bus.wr_en && !bus.soft_rst;
	// Alert compare, inputs only
	assign bus.mismatch = |((live_in ^ in_q) & dir_q);
	assign bus.rd_data = rd_data_q;
	assign bus.out_lvl = out_q;
	assign bus.dir = dir_q;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			dir_q <= DIR_RST;
			out_q <= OUT_RST;
			inv_q <= INV_RST;
		end else if (clk_en && bus.soft_rst) begin
			dir_q <= DIR_RST;
			out_q <= OUT_RST;
			inv_q <= INV_RST;
		end else if (clk_en) begin
			if (wr_hit(PTR_DIR, wr_ok, bus.ptr)) begin
				dir_q <= bus.wr_data;
			end
			if (wr_hit(PTR_OUT, wr_ok, bus.ptr)) begin
				out_q <= bus.wr_data;
			end
			if (wr_hit(PTR_INV, wr_ok, bus.ptr)) begin
				inv_q <= bus.wr_data;
			end
		end
	end

	// Capture on read; input register ignores writes
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			in_q <= IN_RST;
		end else if (clk_en && bus.soft_rst) begin
			in_q <= IN_RST;
		end else if (clk_en && bus.capture && bus.ptr == PTR_IN) begin
			in_q <= rd_data_q;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_q <= IN_RST;
		end else if (clk_en) begin
			rd_data_q <= rd_mux;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	AST_INVERT_VIEW: assert property (clk_en && bus.ptr == PTR_IN |=>
		rd_data_q == ($past(bus.pins) ^ $past(inv_q)))
		else $error("input view not pins xor invert");
	AST_READBACK: assert property (clk_en && bus.ptr == PTR_DIR |=>
		rd_data_q == $past(dir_q))
		else $error("direction readback wrong");
	AST_CAPTURE: assert property (clk_en && !bus.soft_rst && bus.capture &&
		bus.ptr == PTR_IN |=> in_q == $past(rd_data_q))
		else $error("input capture missed");
	AST_BANK_RESET: assert property (clk_en && bus.soft_rst |=>
		dir_q == DIR_RST && out_q == OUT_RST && inv_q == INV_RST && in_q == IN_RST)
		else $error("registers not defaulted by reset pin");
endmodule
`default_nettype wire

// ---- rtl/gx_expander.sv ----
// Operation
// - An 8-bit direction register written by the controller sets each pin as input or output.
// - The input register holds pin data and the output register holds driven data, one bit per pin.
// - An 8-bit invert register flips the reported level of each input whose bit is set.
// - The direction, output and invert registers read back their contents; the input pointer reads the live pins xor invert.
// - The open-drain alert is active while any input differs from its held input register bit.
// - Power-on reset loads all register defaults and puts the control machine in its idle state.
// - The external reset pin does the same defaulting and initialisation as power-on reset.
// - Two address-select pins form the low bits of the fixed target address, four devices per bus.
`timescale 1ns/10ps
`default_nettype none
module gx_expander (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic rst_pin_n,
	input wire logic addr_select_bit0,
	input wire logic addr_select_bit1,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	input wire logic [gx_pkg::IO_W-1:0] io_i,
	output logic [gx_pkg::IO_W-1:0] io_o,
	output logic [gx_pkg::IO_W-1:0] io_oe_n,
	output logic alert_o,
	output logic alert_oe_n
);
	import gx_pkg::*;

	gx_regs_if bus ();

	logic [SYNC_W-1:0] sync1_q, sync2_q;
	logic scl_d_q, sda_d_q;
	gx_state_t state_q, state_d;
	logic [3:0] bit_q, bit_d;
	logic [IO_W-1:0] shift_q, shift_d;
	logic [PTR_W-1:0] ptr_q, ptr_d;
	logic rw_q, rw_d, ack_q, ack_d;
	logic sda_oe_n_q, oe_n_d;
	logic [IO_W-1:0] io_o_q, io_oe_n_q;
	logic alert_oe_n_q;

	wire [SYNC_W-1:0] raw_in = {io_i, rst_pin_n, addr_select_bit1, addr_select_bit0, sda_i, scl_i};
	wire scl_s = sync2_q[SY_SCL];
	wire sda_s = sync2_q[SY_SDA];
	wire soft_rst = !sync2_q[SY_RST];
	wire scl_rise = scl_s && !scl_d_q;
	wire scl_fall = !scl_s && scl_d_q;
	wire start_cond = scl_s && scl_d_q && sda_d_q && !sda_s;
	wire stop_cond = scl_s && scl_d_q && !sda_d_q && sda_s;
	wire byte_done = (bit_q == BIT_LAST);
	wire addr_hit = (shift_q[IO_W-1:1] == {ADDR_BASE, sync2_q[SY_A1], sync2_q[SY_A0]});
	wire in_ack = (state_q == ST_ADDR_ACK) || (state_q == ST_RDATA_ACK);
	wire want_rd = (state_q == ST_ADDR_ACK) ? rw_q : ack_q;
	wire load_rd = clk_en && scl_fall && !start_cond && !stop_cond && in_ack && want_rd;
	wire rx_state = (state_q == ST_ADDR) || (state_q == ST_CMD) || (state_q == ST_WDATA);

	assign bus.wr_en = clk_en && scl_fall && state_q == ST_WDATA && byte_done;
	assign bus.wr_data = shift_q;
	assign bus.ptr = ptr_q;
	assign bus.capture = load_rd;
	assign bus.soft_rst = soft_rst;
	assign bus.pins = sync2_q[SY_IO +: IO_W];

	// Open-drain pins only ever pull low
	assign sda_o = 1'b0;
	assign alert_o = 1'b0;
	assign sda_oe_n = sda_oe_n_q;
	assign io_o = io_o_q;
	assign io_oe_n = io_oe_n_q;
	assign alert_oe_n = alert_oe_n_q;

	gx_regbank u_bank (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.bus(bus)
	);

	// Pins and the bus clock cross in here
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= SYNC_RST;
			sync2_q <= SYNC_RST;
			scl_d_q <= 1'b1;
			sda_d_q <= 1'b1;
		end else if (clk_en) begin
			sync1_q <= raw_in;
			sync2_q <= sync1_q;
			scl_d_q <= scl_s;
			sda_d_q <= sda_s;
		end
	end

	// SCL is never stretched, so each bit has a full half period to settle
	always_comb begin
		state_d = state_q;
		bit_d = bit_q;
		shift_d = shift_q;
		ptr_d = ptr_q;
		rw_d = rw_q;
		ack_d = ack_q;
		oe_n_d = sda_oe_n_q;
		if (soft_rst) begin
			state_d = ST_IDLE;
			bit_d = 4'h0;
			shift_d = '0;
			ptr_d = PTR_IN;
			rw_d = 1'b0;
			ack_d = 1'b0;
			oe_n_d = 1'b1;
		end else if (start_cond) begin
			state_d = ST_ADDR;
			bit_d = 4'h0;
			oe_n_d = 1'b1;
		end else if (stop_cond) begin
			state_d = ST_IDLE;
			oe_n_d = 1'b1;
		end else if (scl_rise) begin
			if (rx_state) begin
				shift_d = {shift_q[IO_W-2:0], sda_s};
				bit_d = bit_q + 4'h1;
			end else if (state_q == ST_RDATA) begin
				bit_d = bit_q + 4'h1;
			end else if (state_q == ST_RDATA_ACK) begin
				ack_d = !sda_s;
			end
		end else if (scl_fall) begin
			unique case (state_q)
				ST_IDLE: begin
				end
				ST_ADDR: begin
					if (byte_done && addr_hit) begin
						state_d = ST_ADDR_ACK;
						rw_d = shift_q[0];
						oe_n_d = 1'b0;
					end else if (byte_done) begin
						state_d = ST_IDLE;
					end
				end
				ST_CMD: begin
					if (byte_done) begin
						ptr_d = shift_q[PTR_W-1:0];
						state_d = ST_CMD_ACK;
						oe_n_d = 1'b0;
					end
				end
				ST_WDATA: begin
					if (byte_done) begin
						state_d = ST_WDATA_ACK;
						oe_n_d = 1'b0;
					end
				end
				ST_ADDR_ACK, ST_RDATA_ACK: begin
					bit_d = 4'h0;
					if (want_rd) begin
						shift_d = bus.rd_data;
						oe_n_d = bus.rd_data[IO_W-1];
						state_d = ST_RDATA;
					end else begin
						oe_n_d = 1'b1;
						state_d = (state_q == ST_ADDR_ACK) ? ST_CMD : ST_IDLE;
					end
				end
				ST_CMD_ACK, ST_WDATA_ACK: begin
					bit_d = 4'h0;
					oe_n_d = 1'b1;
					state_d = ST_WDATA;
				end
				ST_RDATA: begin
					if (byte_done) begin
						oe_n_d = 1'b1;
						state_d = ST_RDATA_ACK;
					end else begin
						shift_d = {shift_q[IO_W-2:0], 1'b0};
						oe_n_d = shift_q[IO_W-2];
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			bit_q <= 4'h0;
			shift_q <= '0;
			ptr_q <= PTR_IN;
			rw_q <= 1'b0;
			ack_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (clk_en) begin
			state_q <= state_d;
			bit_q <= bit_d;
			shift_q <= shift_d;
			ptr_q <= ptr_d;
			rw_q <= rw_d;
			ack_q <= ack_d;
			sda_oe_n_q <= oe_n_d;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			io_o_q <= OUT_RST;
			io_oe_n_q <= DIR_RST;
			alert_oe_n_q <= 1'b1;
		end else if (clk_en) begin
			io_o_q <= bus.out_lvl;
			io_oe_n_q <= bus.dir;
			alert_oe_n_q <= !bus.mismatch;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_addr_byte;
		clk_en && !soft_rst && scl_fall && state_q == ST_ADDR && byte_done;
	endsequence
	sequence s_reg_wr(logic [PTR_W-1:0] p);
		clk_en && !soft_rst && bus.wr_en && bus.ptr == p ##1 clk_en && !soft_rst;
	endsequence

	AST_ADDR_ACK: assert property (s_addr_byte and addr_hit |=>
		state_q == ST_ADDR_ACK && !sda_oe_n_q)
		else $error("own address not acknowledged");
	AST_ADDR_NACK: assert property (s_addr_byte and !addr_hit |=>
		state_q == ST_IDLE && sda_oe_n_q)
		else $error("foreign address acknowledged");
	AST_OUT_PINS: assert property (s_reg_wr(PTR_OUT) |=>
		io_o_q == $past(bus.wr_data, 2))
		else $error("output write not on pins");
	AST_DIR_PINS: assert property (s_reg_wr(PTR_DIR) |=>
		io_oe_n_q == $past(bus.wr_data, 2))
		else $error("direction write not on pin enables");
	AST_ALERT_SET: assert property (clk_en && bus.mismatch |=> !alert_oe_n_q)
		else $error("alert not active on input change");
	AST_ALERT_CLEAR: assert property (clk_en && !bus.mismatch |=> alert_oe_n_q)
		else $error("alert stuck after match");
	AST_PIN_RESET: assert property (clk_en && soft_rst |=>
		state_q == ST_IDLE && sda_oe_n_q && ptr_q == PTR_IN)
		else $error("reset pin did not initialise machine");
	AST_INIT_STATE: assert property ($rose(reset_n) |->
		state_q == ST_IDLE && sda_oe_n_q && alert_oe_n_q)
		else $error("machine not idle after power-on reset");
endmodule
`default_nettype wire

// ---- test/gx_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module gx_host_model (
	output logic scl,
	output logic sda_h,
	input wire logic sda
);
	localparam realtime QTR = 31.25;
	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	// Start or repeated start: SDA falls while SCL high
	task automatic start();
		#QTR sda_h = 1'b1;
		#QTR scl = 1'b1;
		#QTR sda_h = 1'b0;
		#QTR scl = 1'b0;
	endtask
	// Both lines released after stop, so SCL stands still between frames
	task automatic stop();
		#QTR sda_h = 1'b0;
		#QTR scl = 1'b1;
		#QTR sda_h = 1'b1;
		#QTR;
	endtask
	// Byte MSB first, then ninth bit; a one releases SDA for the device
	task automatic xfer(input logic [7:0] tx, input logic nack, output logic [7:0] rx,
		output logic ack);
		logic r;
		for (int i = 7; i >= -1; i--) begin
			#QTR sda_h = (i >= 0) ? tx[i] : nack;
			#QTR scl = 1'b1;
			#(2 * QTR) r = sda;
			scl = 1'b0;
			if (i >= 0) rx[i] = r;
			else ack = !r;
		end
	endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import gx_pkg::*;
	logic clk_sys, reset_n, clk_en, rst_pin_n, addr_select_bit0, addr_select_bit1;
	logic sda_o, sda_oe_n, alert_o, alert_oe_n, scl, sda_h;
	logic [IO_W-1:0] io_i, io_o, io_oe_n;
	wire sda_line;
	int err_count, comparisons;
	int cycles = 0;
	// Open-drain wired AND with pull-up
	assign sda_line = sda_h & (sda_oe_n | sda_o);
	gx_host_model host (.scl(scl), .sda_h(sda_h), .sda(sda_line));
	gx_expander dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
		.rst_pin_n(rst_pin_n), .addr_select_bit0(addr_select_bit0),
		.addr_select_bit1(addr_select_bit1), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .io_i(io_i), .io_o(io_o), .io_oe_n(io_oe_n),
		.alert_o(alert_o), .alert_oe_n(alert_oe_n));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic results();
		if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			results();
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic settle();
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic head(input logic [7:0] ptr);
		logic [7:0] rx;
		logic a;
		host.start();
		host.xfer({ADDR_BASE, addr_select_bit1, addr_select_bit0, 1'b0}, 1'b1, rx, a);
		host.xfer(ptr, 1'b1, rx, a);
		chk("cmd ack", 8'h01, {7'h00, a});
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
		logic [7:0] rx;
		logic a;
		head(ptr);
		host.xfer(val, 1'b1, rx, a);
		chk("data ack", 8'h01, {7'h00, a});
		host.stop();
		settle();
	endtask
	task automatic rdchk(input logic [7:0] ptr, input logic [7:0] exp);
		logic [7:0] val;
		logic a;
		head(ptr);
		host.start();
		host.xfer({ADDR_BASE, addr_select_bit1, addr_select_bit0, 1'b1}, 1'b1, val, a);
		host.xfer(8'hff, 1'b1, val, a);
		host.stop();
		chk("read data", exp, val);
		settle();
	endtask
	task automatic test_defaults();
		chk("dir pins", 8'hff, io_oe_n);
		chk("out pins", 8'hff, io_o);
		chk("pull lows", 8'h00, {6'h00, sda_o, alert_o});
		chk("alert on", 8'h00, {7'h00, alert_oe_n});
		rdchk(PTR_OUT, 8'hff);
		rdchk(PTR_INV, 8'h00);
		rdchk(PTR_DIR, 8'hff);
		rdchk(PTR_IN, 8'hff);
		chk("alert off", 8'h01, {7'h00, alert_oe_n});
	endtask
	task automatic test_dir_out();
		wr(PTR_DIR, 8'h0f);
		wr(PTR_OUT, 8'ha5);
		chk("dir pins", 8'h0f, io_oe_n);
		chk("out pins", 8'ha5, io_o);
		rdchk(PTR_DIR, 8'h0f);
		rdchk(PTR_OUT, 8'ha5);
	endtask
	task automatic test_invert();
		@(posedge clk_sys) io_i <= 8'h5a;
		settle();
		chk("alert on", 8'h00, {7'h00, alert_oe_n});
		wr(PTR_INV, 8'h03);
		rdchk(PTR_INV, 8'h03);
		rdchk(PTR_IN, 8'h59);
		chk("alert off", 8'h01, {7'h00, alert_oe_n});
		@(posedge clk_sys) io_i <= 8'h5b;
		settle();
		chk("alert input", 8'h00, {7'h00, alert_oe_n});
		// Output bits must not raise the alert
		@(posedge clk_sys) io_i <= 8'hda;
		settle();
		chk("alert output", 8'h01, {7'h00, alert_oe_n});
	endtask
	task automatic test_address();
		logic [7:0] rx;
		logic a;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_sys);
			addr_select_bit0 <= k[0];
			addr_select_bit1 <= k[1];
			settle();
			for (int j = 0; j < 4; j++) begin
				host.start();
				host.xfer({ADDR_BASE, j[1:0], 1'b0}, 1'b1, rx, a);
				host.stop();
				chk("addr ack", {7'h00, j == k}, {7'h00, a});
			end
		end
	endtask
	task automatic test_pin_reset();
		@(posedge clk_sys) rst_pin_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		rst_pin_n <= 1'b1;
		settle();
		chk("dir pins", 8'hff, io_oe_n);
		chk("out pins", 8'hff, io_o);
		rdchk(PTR_INV, 8'h00);
	endtask
	task automatic test_repeat_read();
		logic [7:0] v0, v1;
		logic a;
		// Input register takes no write, so the alert must stay off
		wr(PTR_IN, 8'h00);
		chk("input write", 8'h01, {7'h00, alert_oe_n});
		head(PTR_OUT);
		host.start();
		host.xfer({ADDR_BASE, addr_select_bit1, addr_select_bit0, 1'b1}, 1'b1, v0, a);
		host.xfer(8'hff, 1'b0, v0, a);
		host.xfer(8'hff, 1'b1, v1, a);
		host.stop();
		chk("read first", 8'ha5, v0);
		chk("read again", 8'ha5, v1);
		settle();
	endtask
	task automatic test_freeze();
		rdchk(PTR_IN, 8'hda);
		chk("alert off", 8'h01, {7'h00, alert_oe_n});
		// Enable low must hold every flop, synchronisers included
		@(posedge clk_sys) clk_en <= 1'b0;
		io_i <= 8'h25;
		settle();
		chk("alert frozen", 8'h01, {7'h00, alert_oe_n});
		@(posedge clk_sys) clk_en <= 1'b1;
		settle();
		chk("alert thawed", 8'h00, {7'h00, alert_oe_n});
	endtask
	task automatic test_power_reset();
		wr(PTR_DIR, 8'h00);
		wr(PTR_OUT, 8'h3c);
		wr(PTR_INV, 8'h81);
		chk("dir pins", 8'h00, io_oe_n);
		chk("out pins", 8'h3c, io_o);
		@(posedge clk_sys) reset_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		settle();
		chk("dir pins", 8'hff, io_oe_n);
		chk("out pins", 8'hff, io_o);
		rdchk(PTR_INV, 8'h00);
	endtask
	initial begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		rst_pin_n = 1'b1;
		addr_select_bit0 = 1'b0;
		addr_select_bit1 = 1'b0;
		io_i = 8'hff;
		err_count = 0;
		comparisons = 0;
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		settle();
		test_defaults();
		test_dir_out();
		test_repeat_read();
		test_invert();
		test_address();
		test_pin_reset();
		test_freeze();
		test_power_reset();
		results();
	end
endmodule
`default_nettype wire
